// ---- rtl/load_switch_bank.sv ----
// i2c target and register bank for three load switch drivers
// assumes scl/sda arrive asynchronously; sda is open drain, driven low only
//
// Contract
// - an enabled switch whose output falls below the uv threshold sets its flag at bit 0, 1 or 2.
// - a uv flag stays set until the interrupt register is read or its switch is disabled, and the read returns then clears it.
// - a disabled switch reads its uv flag as zero and records no event.
// - interrupt register bits 7 to 3 have no function, are written zero and read as anything.
// - config bit 5 picks the system supply rail when one, else the selected internal buck.
// - config bits 4:3 pick buck one for 00, buck two for 01 and buck three for 1x.
// - config bits 2:0 of switches one and two set the pump frequency, 12.5kHz doubling to 1600kHz.
// - config bits 7:6, and bits 2:0 of switch three, are reserved, written zero, read meaningless.
`timescale 1ns/1ps
module load_switch_bank #(
    parameter logic [6:0]  TARGET_ADDR = lsw_regs_pkg::TARGET_ADDR,
    parameter logic [12:0] CP_HALF_BASE =
        13'(lsw_regs_pkg::CP_HALF_CYCLES_BASE)
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // i2c pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output      logic        sda_o,
    output      logic        sda_oe_o,
    // switch status from the power stages
    input  wire logic [2:0]  switch_enable_i,
    input  wire logic [2:0]  uv_level_i,
    // switch controls
    output      logic [3:0]  switch1_source_o,
    output      logic [3:0]  switch2_source_o,
    output      logic [3:0]  switch3_source_o,
    output      logic        switch1_gate_pump_clk_o,
    output      logic        switch2_gate_pump_clk_o
);

    localparam int N = lsw_regs_pkg::NUM_SWITCHES;
    localparam logic [7:0] CFG_ADDR [N] = '{
        lsw_regs_pkg::CFG1_ADDR, lsw_regs_pkg::CFG2_ADDR,
        lsw_regs_pkg::CFG3_ADDR};
    localparam logic [7:0] CFG_RESET [N] = '{
        lsw_regs_pkg::CFG1_RESET, lsw_regs_pkg::CFG2_RESET,
        lsw_regs_pkg::CFG3_RESET};

    typedef struct packed {
        logic [2:0]               scl_sync;
        logic [2:0]               sda_sync;
        logic                     scl;
        logic                     sda;
        lsw_regs_pkg::i2c_state_t state;
        logic [3:0]               bits;
        logic [7:0]               rx;
        logic [7:0]               tx;
        logic [7:0]               ptr;
        logic                     rw;
        logic                     nack;
        logic                     oe;
    } bank_state_t;

    bank_state_t b_q, b_d;
    logic [N-1:0] wr_pulse;
    logic         rd_clear;
    logic [N-1:0] uv_flags;
    logic [7:0]   cfg_rd [N];
    logic [3:0]   route [N];
    logic [N-1:0] pump;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sw
            switch_reg_if bus ();
            assign bus.write_pulse = wr_pulse[g];
            assign bus.write_data  = b_q.rx;
            assign bus.read_clear  = rd_clear;
            assign uv_flags[g]     = bus.uv_flag;
            assign cfg_rd[g]       = bus.cfg_readback;
            load_switch_slice #(
                .RESET_VALUE  (CFG_RESET[g]),
                .HAS_DRIVE    (g < 2),
                .CP_HALF_BASE (CP_HALF_BASE)
            ) u_slice (
                .ref_clk_i       (ref_clk_i),
                .reset_i         (reset_i),
                .switch_enable_i (switch_enable_i[g]),
                .uv_level_i      (uv_level_i[g]),
                .source_route_o  (route[g]),
                .gate_pump_clk_o (pump[g]),
                .regs            (bus.slice)
            );
        end
    endgenerate

    // read mux; unmapped addresses read zero
    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == lsw_regs_pkg::UV_FLAGS_ADDR) begin
            r = {5'b00000, uv_flags};
        end
        for (int i = 0; i < N; i++) begin
            if (a == CFG_ADDR[i]) begin
                r = cfg_rd[i];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic load_tx;
        scl_rise   = 1'b0;
        scl_fall   = 1'b0;
        start_seen = 1'b0;
        stop_seen  = 1'b0;
        load_tx    = 1'b0;
        wr_pulse   = '0;
        rd_clear   = 1'b0;
        b_d = b_q;
        b_d.scl_sync = {b_q.scl_sync[1:0], scl_i};
        b_d.sda_sync = {b_q.sda_sync[1:0], sda_i};
        if (b_q.scl_sync[1] == b_q.scl_sync[2]) begin
            b_d.scl  = b_q.scl_sync[2];
            scl_rise = b_q.scl_sync[2] & ~b_q.scl;
            scl_fall = ~b_q.scl_sync[2] & b_q.scl;
        end
        if (b_q.sda_sync[1] == b_q.sda_sync[2]) begin
            b_d.sda    = b_q.sda_sync[2];
            // sda moving in the clock that scl falls is data, not a frame
            start_seen = b_q.scl & b_q.scl_sync[2] & b_q.sda
                       & ~b_q.sda_sync[2];
            stop_seen  = b_q.scl & b_q.scl_sync[2] & ~b_q.sda
                       & b_q.sda_sync[2];
        end

        if (start_seen) begin
            b_d.state = lsw_regs_pkg::ST_ADDR;
            b_d.bits  = '0;
            b_d.oe    = 1'b0;
        end else if (stop_seen) begin
            b_d.state = lsw_regs_pkg::ST_IDLE;
            b_d.oe    = 1'b0;
        end else if (scl_rise) begin
            unique case (b_q.state)
                lsw_regs_pkg::ST_ADDR,
                lsw_regs_pkg::ST_PTR,
                lsw_regs_pkg::ST_WDATA: begin
                    b_d.rx   = {b_q.rx[6:0], b_q.sda};
                    b_d.bits = b_q.bits + 4'h1;
                end
                lsw_regs_pkg::ST_RDATA_ACK: begin
                    b_d.nack = b_q.sda;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (b_q.state)
                lsw_regs_pkg::ST_IDLE: begin
                end
                lsw_regs_pkg::ST_ADDR: begin
                    if (b_q.bits == lsw_regs_pkg::BYTE_BITS) begin
                        if (b_q.rx[7:1] == TARGET_ADDR) begin
                            b_d.rw    = b_q.rx[0];
                            b_d.oe    = 1'b1;
                            b_d.state = lsw_regs_pkg::ST_ADDR_ACK;
                        end else begin
                            b_d.state = lsw_regs_pkg::ST_IDLE;
                        end
                    end
                end
                lsw_regs_pkg::ST_ADDR_ACK: begin
                    b_d.oe   = 1'b0;
                    b_d.bits = '0;
                    if (b_q.rw) begin
                        load_tx = 1'b1;
                    end else begin
                        b_d.state = lsw_regs_pkg::ST_PTR;
                    end
                end
                lsw_regs_pkg::ST_PTR: begin
                    if (b_q.bits == lsw_regs_pkg::BYTE_BITS) begin
                        b_d.ptr   = b_q.rx;
                        b_d.oe    = 1'b1;
                        b_d.state = lsw_regs_pkg::ST_PTR_ACK;
                    end
                end
                lsw_regs_pkg::ST_WDATA: begin
                    if (b_q.bits == lsw_regs_pkg::BYTE_BITS) begin
                        // the flag register clears by reading or by disabling its switch, never by a write
                        for (int i = 0; i < N; i++) begin
                            wr_pulse[i] = (b_q.ptr == CFG_ADDR[i]);
                        end
                        b_d.ptr   = b_q.ptr + 8'h01;
                        b_d.oe    = 1'b1;
                        b_d.state = lsw_regs_pkg::ST_WDATA_ACK;
                    end
                end
                lsw_regs_pkg::ST_PTR_ACK,
                lsw_regs_pkg::ST_WDATA_ACK: begin
                    b_d.oe    = 1'b0;
                    b_d.bits  = '0;
                    b_d.state = lsw_regs_pkg::ST_WDATA;
                end
                lsw_regs_pkg::ST_RDATA: begin
                    if (b_q.bits == lsw_regs_pkg::LAST_BIT) begin
                        b_d.oe    = 1'b0;
                        b_d.ptr   = b_q.ptr + 8'h01;
                        b_d.state = lsw_regs_pkg::ST_RDATA_ACK;
                    end else begin
                        b_d.tx   = {b_q.tx[6:0], 1'b0};
                        b_d.oe   = ~b_q.tx[6];
                        b_d.bits = b_q.bits + 4'h1;
                    end
                end
                lsw_regs_pkg::ST_RDATA_ACK: begin
                    b_d.bits = '0;
                    if (b_q.nack) begin
                        b_d.state = lsw_regs_pkg::ST_IDLE;
                    end else begin
                        load_tx = 1'b1;
                    end
                end
                default: begin
                    b_d.state = lsw_regs_pkg::ST_IDLE;
                    b_d.oe    = 1'b0;
                end
            endcase
        end

        // snapshot and clear in one cycle, so no event slips between them
        if (load_tx) begin
            b_d.tx    = read_reg(b_q.ptr);
            b_d.oe    = ~b_d.tx[7];
            b_d.state = lsw_regs_pkg::ST_RDATA;
            rd_clear  = (b_q.ptr == lsw_regs_pkg::UV_FLAGS_ADDR);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            b_q <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl: 1'b1, sda: 1'b1,
                     state: lsw_regs_pkg::ST_IDLE, bits: 4'h0, rx: 8'h00,
                     tx: 8'h00, ptr: 8'h00, rw: 1'b0, nack: 1'b0,
                     oe: 1'b0};
        end else begin
            b_q <= b_d;
        end
    end

    assign sda_o                   = 1'b0;
    assign sda_oe_o                = b_q.oe;
    assign switch1_source_o        = route[0];
    assign switch2_source_o        = route[1];
    assign switch3_source_o        = route[2];
    assign switch1_gate_pump_clk_o = pump[0];
    assign switch2_gate_pump_clk_o = pump[1];

endmodule

// ---- rtl/lsw_regs_pkg.sv ----
// constants, field layout and i2c target states for the load switch bank
// assumes one 125 MHz clock and the i2c pins arriving from outside
package lsw_regs_pkg;

    localparam int NUM_SWITCHES = 3;
    localparam int SYNC_STAGES  = 3;

    // register addresses
    localparam logic [7:0] UV_FLAGS_ADDR = 8'h03;
    localparam logic [7:0] CFG1_ADDR     = 8'h69;
    localparam logic [7:0] CFG2_ADDR     = 8'h6a;
    localparam logic [7:0] CFG3_ADDR     = 8'h6b;

    // reset values
    localparam logic [7:0] CFG1_RESET = 8'h0d;
    localparam logic [7:0] CFG2_RESET = 8'h25;
    localparam logic [7:0] CFG3_RESET = 8'h20;
    localparam logic [2:0] UV_RESET   = 3'h0;

    // configuration field positions
    localparam int EXT_BIT  = 5;
    localparam int SEL_HI   = 4;
    localparam int SEL_LO   = 3;
    localparam int FREQ_HI  = 2;
    localparam int FREQ_LO  = 0;

    // buck selection codes; any code with the high bit set means buck three
    localparam logic [1:0] SEL_BUCK_ONE = 2'h0;
    localparam logic [1:0] SEL_BUCK_TWO = 2'h1;

    // one-hot source route bit positions
    localparam int ROUTE_SYSTEM     = 0;
    localparam int ROUTE_BUCK_ONE   = 1;
    localparam int ROUTE_BUCK_TWO   = 2;
    localparam int ROUTE_BUCK_THREE = 3;
    localparam int ROUTE_W          = 4;

    // i2c target
    localparam logic [6:0] TARGET_ADDR = 7'h60;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] LAST_BIT    = 4'h7;

    // charge pump oscillator: slowest code runs at the base frequency
    localparam real CLK_FREQ_KHZ     = 125000.0;
    localparam real CP_BASE_FREQ_KHZ = 12.5;
    localparam int  CP_HALF_CYCLES_BASE =
        $rtoi(CLK_FREQ_KHZ / (2.0 * CP_BASE_FREQ_KHZ));
    localparam int  CP_CNT_W = 13;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_PTR       = 4'b0011,
        ST_PTR_ACK   = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA     = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } i2c_state_t;

endpackage

// ---- rtl/switch_reg_if.sv ----
// register-side signals between the bank top and one switch slice
// assumes all signals live on the single system clock
`timescale 1ns/1ps
interface switch_reg_if;
    logic       write_pulse;
    logic [7:0] write_data;
    logic       read_clear;
    logic       uv_flag;
    logic [7:0] cfg_readback;

    modport bank  (output write_pulse, write_data, read_clear,
                   input  uv_flag, cfg_readback);
    modport slice (input  write_pulse, write_data, read_clear,
                   output uv_flag, cfg_readback);
endinterface

// ---- rtl/load_switch_slice.sv ----
// one load switch: config register, undervoltage flag, charge pump clock
// assumes enable comes from logic on ref_clk_i, uv level from a comparator
`timescale 1ns/1ps
module load_switch_slice #(
    parameter logic [7:0]  RESET_VALUE = lsw_regs_pkg::CFG1_RESET,
    parameter bit          HAS_DRIVE   = 1'b1,
    parameter logic [12:0] CP_HALF_BASE =
        13'(lsw_regs_pkg::CP_HALF_CYCLES_BASE)
) (
    // clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          reset_i,
    // analog side
    input  wire logic                          switch_enable_i,
    input  wire logic                          uv_level_i,
    output      logic [lsw_regs_pkg::ROUTE_W-1:0] source_route_o,
    output      logic                          gate_pump_clk_o,
    // register side
    switch_reg_if.slice                        regs
);

    typedef struct packed {
        logic                ext;
        logic [1:0]          sel;
        logic [2:0]          freq;
        logic                uv;
        logic [2:0]          uv_sync;
        logic                uv_stable;
        logic [3:0]          route;
        logic [12:0]         cnt;
        logic                pump;
    } slice_state_t;

    slice_state_t s_q, s_d;

    // decode the reset route too, so the outputs are one-hot from reset on
    localparam logic [1:0] RESET_SEL =
        RESET_VALUE[lsw_regs_pkg::SEL_HI:lsw_regs_pkg::SEL_LO];
    localparam int RESET_BIT =
        RESET_VALUE[lsw_regs_pkg::EXT_BIT] ? lsw_regs_pkg::ROUTE_SYSTEM
        : (RESET_SEL == lsw_regs_pkg::SEL_BUCK_ONE)
            ? lsw_regs_pkg::ROUTE_BUCK_ONE
        : (RESET_SEL == lsw_regs_pkg::SEL_BUCK_TWO)
            ? lsw_regs_pkg::ROUTE_BUCK_TWO
        : lsw_regs_pkg::ROUTE_BUCK_THREE;
    localparam logic [3:0] RESET_ROUTE = 4'h1 << RESET_BIT;

    always_comb begin
        logic       uv_rise;
        logic [7:0] w;
        uv_rise = 1'b0;
        w = regs.write_data;
        s_d = s_q;
        s_d.uv_sync = {s_q.uv_sync[1:0], uv_level_i};
        // a change counts once the last two stages agree
        if (s_q.uv_sync[1] == s_q.uv_sync[2]) begin
            s_d.uv_stable = s_q.uv_sync[2];
            uv_rise = s_q.uv_sync[2] & ~s_q.uv_stable;
        end
        if (regs.write_pulse) begin
            s_d.ext = w[lsw_regs_pkg::EXT_BIT];
            s_d.sel = w[lsw_regs_pkg::SEL_HI:lsw_regs_pkg::SEL_LO];
            if (HAS_DRIVE) begin
                s_d.freq = w[lsw_regs_pkg::FREQ_HI:lsw_regs_pkg::FREQ_LO];
            end
        end
        // set beats the read clear; disabled switch holds no flag
        s_d.uv = switch_enable_i
               & ((uv_rise & switch_enable_i)
                  | (s_q.uv & ~regs.read_clear));
        s_d.route = '0;
        if (s_d.ext) begin
            s_d.route[lsw_regs_pkg::ROUTE_SYSTEM] = 1'b1;
        end else if (s_d.sel == lsw_regs_pkg::SEL_BUCK_ONE) begin
            s_d.route[lsw_regs_pkg::ROUTE_BUCK_ONE] = 1'b1;
        end else if (s_d.sel == lsw_regs_pkg::SEL_BUCK_TWO) begin
            s_d.route[lsw_regs_pkg::ROUTE_BUCK_TWO] = 1'b1;
        end else begin
            s_d.route[lsw_regs_pkg::ROUTE_BUCK_THREE] = 1'b1;
        end
        // each code step halves the half period, doubling the frequency
        if (HAS_DRIVE) begin
            if (s_q.cnt >= (CP_HALF_BASE >> s_q.freq) - 13'h0001) begin
                s_d.cnt  = '0;
                s_d.pump = ~s_q.pump;
            end else begin
                s_d.cnt = s_q.cnt + 13'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            s_q.ext       <= RESET_VALUE[lsw_regs_pkg::EXT_BIT];
            s_q.sel       <= RESET_VALUE[lsw_regs_pkg::SEL_HI:
                                         lsw_regs_pkg::SEL_LO];
            s_q.freq      <= HAS_DRIVE ?
                RESET_VALUE[lsw_regs_pkg::FREQ_HI:lsw_regs_pkg::FREQ_LO]
                : 3'h0;
            s_q.uv        <= 1'b0;
            s_q.uv_sync   <= 3'h0;
            s_q.uv_stable <= 1'b0;
            s_q.route     <= RESET_ROUTE;
            s_q.cnt       <= 13'h0000;
            s_q.pump      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // reserved bits read back as zero
    assign regs.uv_flag      = s_q.uv;
    assign regs.cfg_readback = {2'b00, s_q.ext, s_q.sel, s_q.freq};
    assign source_route_o    = s_q.route;
    assign gate_pump_clk_o   = s_q.pump;

endmodule

// ---- tb/lsw_bank_monitor.sv ----
// assertion checker for the load switch register bank
// assumes it is bound onto load_switch_bank and sees only its ports
`timescale 1ns/1ps
module lsw_bank_monitor #(
    parameter logic [12:0] CP_HALF_BASE =
        13'(lsw_regs_pkg::CP_HALF_CYCLES_BASE)
) (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       reset_i,
    // i2c pins
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    // switch side
    input wire logic [2:0] switch_enable_i,
    input wire logic [2:0] uv_level_i,
    input wire logic [3:0] switch1_source_o,
    input wire logic [3:0] switch2_source_o,
    input wire logic [3:0] switch3_source_o,
    input wire logic       switch1_gate_pump_clk_o,
    input wire logic       switch2_gate_pump_clk_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // cycles since each pump clock last moved; bounds the slowest code
    logic [13:0] gap1_q;
    logic [13:0] gap2_q;
    always_ff @(posedge ref_clk_i) begin
        gap1_q <= (reset_i || $changed(switch1_gate_pump_clk_o))
                  ? 14'h0 : gap1_q + 14'h1;
        gap2_q <= (reset_i || $changed(switch2_gate_pump_clk_o))
                  ? 14'h0 : gap2_q + 14'h1;
    end

    sequence pump1_rise;
        $rose(switch1_gate_pump_clk_o);
    endsequence
    sequence pump1_hold;
        switch1_gate_pump_clk_o [*2];
    endsequence

    chk_route_one_hot1: assert property ($onehot(switch1_source_o))
        else $error("switch 1 route not one-hot");
    chk_route_one_hot2: assert property ($onehot(switch2_source_o))
        else $error("switch 2 route not one-hot");
    chk_route_one_hot3: assert property ($onehot(switch3_source_o))
        else $error("switch 3 route not one-hot");
    chk_reset_routes: assert property ($fell(reset_i) |->
        switch1_source_o == 4'h4 && switch2_source_o == 4'h1 &&
        switch3_source_o == 4'h1 && !switch1_gate_pump_clk_o &&
        !switch2_gate_pump_clk_o)
        else $error("routes or pumps wrong after reset");
    chk_pump1_hold: assert property (pump1_rise |-> pump1_hold)
        else $error("pump 1 high phase too short");
    chk_pump1_period: assert property (int'(gap1_q) < int'(CP_HALF_BASE) + 8)
        else $error("pump 1 stopped toggling");
    chk_pump2_period: assert property (int'(gap2_q) < int'(CP_HALF_BASE) + 8)
        else $error("pump 2 stopped toggling");
    chk_sda_drive_low: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("data line driven high");
    chk_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("data line taken while clock high");
endmodule

bind load_switch_bank lsw_bank_monitor #(.CP_HALF_BASE(CP_HALF_BASE)) mon_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .switch_enable_i(switch_enable_i), .uv_level_i(uv_level_i),
    .switch1_source_o(switch1_source_o),
    .switch2_source_o(switch2_source_o),
    .switch3_source_o(switch3_source_o),
    .switch1_gate_pump_clk_o(switch1_gate_pump_clk_o),
    .switch2_gate_pump_clk_o(switch2_gate_pump_clk_o)
);

// ---- tb/tb_top.sv ----
// self-checking bench for the load switch bank, driven over i2c
// assumes an open-drain data line with a pull-up, as on the board
`timescale 1ns/1ps
module tb_top;
    localparam logic [12:0] HALF_BASE = 13'h0100;
    logic       ref_clk_i       = 1'b0;
    logic       reset_i         = 1'b1;
    logic       scl_i           = 1'b1;
    logic       m_sda           = 1'b1;
    logic [2:0] switch_enable_i = 3'h0;
    logic [2:0] uv_level_i      = 3'h0;
    logic       sda_i;
    logic       sda_o;
    logic       sda_oe_o;
    logic [3:0] src_o [3];
    logic [1:0] pump_o;
    int         errors          = 0;
    int         total_checks    = 0;
    int         acks            = 0;

    always #4 ref_clk_i = ~ref_clk_i;
    // pull-up: the line is low only while someone pulls it
    assign sda_i = m_sda & !(sda_oe_o === 1'b1);

    load_switch_bank #(.CP_HALF_BASE(HALF_BASE)) dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl_i),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .switch_enable_i(switch_enable_i), .uv_level_i(uv_level_i),
        .switch1_source_o(src_o[0]), .switch2_source_o(src_o[1]),
        .switch3_source_o(src_o[2]),
        .switch1_gate_pump_clk_o(pump_o[0]),
        .switch2_gate_pump_clk_o(pump_o[1])
    );

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // scl phases of 10 clocks keep well above the sync latency
    task automatic half();
        repeat (10) @(negedge ref_clk_i);
    endtask

    task automatic bit_out(input logic b);
        m_sda = b;
        half();
        scl_i = 1'b1;
        half();
        scl_i = 1'b0;
    endtask

    task automatic bit_in(output logic b);
        m_sda = 1'b1;
        half();
        scl_i = 1'b1;
        half();
        b = sda_i;
        scl_i = 1'b0;
    endtask

    task automatic start();
        m_sda = 1'b1;
        half();
        scl_i = 1'b1;
        half();
        m_sda = 1'b0;
        half();
        scl_i = 1'b0;
    endtask

    task automatic stop();
        m_sda = 1'b0;
        half();
        scl_i = 1'b1;
        half();
        m_sda = 1'b1;
        half();
    endtask

    task automatic byte_out(input logic [7:0] v, input logic exp_ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_in(a);
        acks++;
        check("ack", 16'(!a), 16'(exp_ack));
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        start();
        byte_out({lsw_regs_pkg::TARGET_ADDR, 1'b0}, 1'b1);
        byte_out(a, 1'b1);
        start();
        byte_out({lsw_regs_pkg::TARGET_ADDR, 1'b1}, 1'b1);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(1'b1);
        stop();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        byte_out({lsw_regs_pkg::TARGET_ADDR, 1'b0}, 1'b1);
        byte_out(a, 1'b1);
        byte_out(d, 1'b1);
        stop();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check("register", 16'(d), 16'(exp));
    endtask

    task automatic pulse(input logic [2:0] m);
        uv_level_i = m;
        repeat (8) @(negedge ref_clk_i);
        uv_level_i = 3'h0;
        repeat (8) @(negedge ref_clk_i);
    endtask

    // length of the last of three pump half periods, in clocks
    task automatic pump_half(input int k, output int n);
        logic p;
        for (int e = 0; e < 3; e++) begin
            p = pump_o[k];
            n = 0;
            while (pump_o[k] === p && n < 4000) begin
                @(negedge ref_clk_i);
                n++;
            end
        end
        if (n >= 4000) begin
            errors++;
            finish_test();
        end
    endtask

    initial begin
        logic [7:0] cfg;
        logic [7:0] r1;
        logic [7:0] r2;
        int         n;
        int         base;
        repeat (10) @(negedge ref_clk_i);
        reset_i = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        check("route1", 16'(src_o[0]), 16'h0004);
        check("route2", 16'(src_o[1]), 16'h0001);
        check("route3", 16'(src_o[2]), 16'h0001);
        rd_chk(8'h69, 8'h0d);
        rd_chk(8'h6a, 8'h25);
        rd_chk(8'h6b, 8'h20);
        rd_chk(8'h03, 8'h00);
        rd_chk(8'h40, 8'h00);
        // a foreign address must not be answered
        start();
        byte_out(8'ha2, 1'b0);
        stop();
        // external select outranks the buck field, hence 8'h38 last
        for (int s = 0; s < 3; s++) begin
            for (int c = 0; c < 5; c++) begin
                cfg = (c == 4) ? 8'h38 : {3'b000, 2'(c), 3'b000};
                wr(lsw_regs_pkg::CFG1_ADDR + 8'(s), cfg);
                rd_chk(lsw_regs_pkg::CFG1_ADDR + 8'(s), cfg);
                check("route", 16'(src_o[s]),
                      16'((c == 4) ? 1 : (c > 1) ? 8 : 2 << c));
            end
        end
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 8; c++) begin
                wr(lsw_regs_pkg::CFG1_ADDR + 8'(k), {5'b00100, 3'(c)});
                pump_half(k, n);
                check("pump half", 16'(n), 16'(HALF_BASE >> c));
            end
        end
        switch_enable_i = 3'b011;
        pulse(3'b111);
        rd_chk(8'h03, 8'h03);
        rd_chk(8'h03, 8'h00);
        switch_enable_i = 3'b111;
        pulse(3'b100);
        rd_chk(8'h03, 8'h04);
        pulse(3'b001);
        switch_enable_i = 3'b110;
        repeat (4) @(negedge ref_clk_i);
        rd_chk(8'h03, 8'h00);
        // sweep an event across the snapshot edge; it must show exactly once
        switch_enable_i = 3'b111;
        for (int k = 0; k < 12; k++) begin
            base = acks;
            fork
                rd(8'h03, r1);
                begin
                    for (int t = 0; t < 3000 && acks != base + 2; t++) begin
                        @(negedge ref_clk_i);
                    end
                    if (acks != base + 2) begin
                        errors++;
                    end
                    repeat (200 + k) @(negedge ref_clk_i);
                    uv_level_i = 3'b010;
                end
            join
            uv_level_i = 3'h0;
            repeat (8) @(negedge ref_clk_i);
            rd(8'h03, r2);
            check("uv race", 16'(r1 ^ r2), 16'h0002);
        end
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge ref_clk_i);
        errors++;
        finish_test();
    end
endmodule
